// file: hdl/plsv_pkg.sv
// Purpose: constants and types for the link status vector block
// Assumes: status word bits [15:7] only; lower bits live elsewhere
// Notes:   field positions refer to the advertisement and partner ability words
package plsv_pkg;

  // operating mode, one-hot
  typedef enum logic [2:0] {
    PLSV_MODE_BASEX     = 3'b001,
    PLSV_MODE_SGMII_MAC = 3'b010,
    PLSV_MODE_SGMII_PHY = 3'b100
  } plsv_mode_t;

  // positions inside the advertisement / link-partner ability words
  localparam int unsigned PLSV_AB_LINK       = 15;
  localparam int unsigned PLSV_AB_RF_HI      = 13;
  localparam int unsigned PLSV_AB_RF_LO      = 12;
  localparam int unsigned PLSV_AB_SGMII_DPX  = 12;
  localparam int unsigned PLSV_AB_SPD_HI     = 11;
  localparam int unsigned PLSV_AB_SPD_LO     = 10;
  localparam int unsigned PLSV_AB_PAUSE_HI   = 8;
  localparam int unsigned PLSV_AB_PAUSE_LO   = 7;
  localparam int unsigned PLSV_AB_BASEX_DPX  = 5;

  // positions inside the status word
  localparam int unsigned PLSV_SV_LSB        = 7;
  localparam int unsigned PLSV_SV_MSB        = 15;
  localparam int unsigned PLSV_SV_LINK       = 7;
  localparam int unsigned PLSV_SV_RFT_LO     = 8;
  localparam int unsigned PLSV_SV_RFT_HI     = 9;
  localparam int unsigned PLSV_SV_SPD_LO     = 10;
  localparam int unsigned PLSV_SV_SPD_HI     = 11;
  localparam int unsigned PLSV_SV_DPX        = 12;
  localparam int unsigned PLSV_SV_RF         = 13;
  localparam int unsigned PLSV_SV_PAUSE_LO   = 14;
  localparam int unsigned PLSV_SV_PAUSE_HI   = 15;

  // fixed codes
  localparam logic [1:0] PLSV_SPEED_1000     = 2'h2;
  localparam logic [1:0] PLSV_RFT_NONE       = 2'h0;
  localparam logic [1:0] PLSV_RFT_LINK_FAIL  = 2'h2;

  // values after reset
  localparam logic [8:0] PLSV_SV_RST         = 9'h000;
  localparam logic       PLSV_RF_RST         = 1'b0;

endpackage

// file: hdl/plsv_status.sv
// Purpose: builds status word bits [15:7] from negotiation results and mode
// Assumes: all inputs come from logic on sys_clk_i (core reference clock)
// Notes:   reset acts without the clock, as the whole core resets that way
// Notes on behaviour
// R1 - in SGMII, bit 7 shows whether the far PHY has link
// R2 - link bit from partner word bit 15 (MAC) or advert bit 15 (PHY)
// R3 - in 1000BASE-X, bit 7 stays low and should be ignored
// R4 - bits 9:8 carry fault type; 1000BASE-X copies partner bits 13:12
// R5 - SGMII PHY side gives 00; MAC side gives 10 when partner link bit low
// R6 - bits 11:10 give speed; 1000BASE-X fixes them at 10
// R7 - SGMII speed from partner 11:10 (MAC) or advert 11:10 (PHY)
// R8 - bit 12 duplex: partner bit 5 (1000BASE-X), 5.12 MAC, 4.12 PHY
// R9 - bit 13 flags remote fault, mirroring status register bit 1.4; SGMII PHY side holds it low
// R10 - fault bit holds until management reads status register 1
// R11 - bits 15:14 copy partner bits 8:7, pause capability, in 1000BASE-X; SGMII gives 00
// R12 - status outputs are synchronous to the core reference clock
// R13 - active-high reset clears the block asynchronously
// R14 - a fault arriving with the clearing read keeps the bit set
`timescale 1ns/1ps
module plsv_status (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       sgmii_mode_i,
  input  wire logic       phy_side_i,
  input  wire logic [15:0] adv_ability_i,
  input  wire logic [15:0] lp_ability_i,
  input  wire logic       rf_detect_i,
  input  wire logic       status_reg1_read_i,
  output logic      [8:0] status_vector_o,
  output logic            remote_fault_o
);
  import plsv_pkg::*;

  plsv_mode_t  mode;
  logic [15:0] sgmii_src;
  logic [8:0]  nxt_sv;
  logic [8:0]  sv_ff;
  logic        nxt_rf;
  logic        rf_ff;

  always_comb begin
    if (!sgmii_mode_i) begin
      mode = PLSV_MODE_BASEX;
    end else if (phy_side_i) begin
      mode = PLSV_MODE_SGMII_PHY;
    end else begin
      mode = PLSV_MODE_SGMII_MAC;
    end
  end

  // sgmii fields come from our own advert on the PHY side
  assign sgmii_src = (mode == PLSV_MODE_SGMII_PHY) ? adv_ability_i : lp_ability_i; // R2 R7

  // set beats clear so a fault in the read cycle survives
  always_comb begin
    nxt_rf = rf_ff;
    if (status_reg1_read_i) begin
      nxt_rf = 1'b0; // R10
    end
    if (rf_detect_i) begin
      nxt_rf = 1'b1; // R14
    end
  end

  always_comb begin
    nxt_sv = PLSV_SV_RST;
    unique case (mode)
      PLSV_MODE_BASEX: begin
        nxt_sv[PLSV_SV_LINK-PLSV_SV_LSB] = 1'b0; // R3
        nxt_sv[PLSV_SV_RFT_HI-PLSV_SV_LSB -: 2] =
          lp_ability_i[PLSV_AB_RF_HI -: 2]; // R4
        nxt_sv[PLSV_SV_SPD_HI-PLSV_SV_LSB -: 2] = PLSV_SPEED_1000; // R6
        nxt_sv[PLSV_SV_DPX-PLSV_SV_LSB] = lp_ability_i[PLSV_AB_BASEX_DPX]; // R8
        nxt_sv[PLSV_SV_RF-PLSV_SV_LSB] = nxt_rf; // R9
        nxt_sv[PLSV_SV_PAUSE_HI-PLSV_SV_LSB -: 2] =
          lp_ability_i[PLSV_AB_PAUSE_HI -: 2]; // R11
      end
      PLSV_MODE_SGMII_MAC: begin
        nxt_sv[PLSV_SV_LINK-PLSV_SV_LSB] = sgmii_src[PLSV_AB_LINK]; // R1
        nxt_sv[PLSV_SV_RFT_HI-PLSV_SV_LSB -: 2] =
          sgmii_src[PLSV_AB_LINK] ? PLSV_RFT_NONE : PLSV_RFT_LINK_FAIL; // R5
        nxt_sv[PLSV_SV_SPD_HI-PLSV_SV_LSB -: 2] = sgmii_src[PLSV_AB_SPD_HI -: 2]; // R7
        nxt_sv[PLSV_SV_DPX-PLSV_SV_LSB] = sgmii_src[PLSV_AB_SGMII_DPX]; // R8
        nxt_sv[PLSV_SV_RF-PLSV_SV_LSB] = nxt_rf; // R9
      end
      PLSV_MODE_SGMII_PHY: begin
        nxt_sv[PLSV_SV_LINK-PLSV_SV_LSB] = sgmii_src[PLSV_AB_LINK]; // R1
        nxt_sv[PLSV_SV_RFT_HI-PLSV_SV_LSB -: 2] = PLSV_RFT_NONE; // R5
        nxt_sv[PLSV_SV_SPD_HI-PLSV_SV_LSB -: 2] = sgmii_src[PLSV_AB_SPD_HI -: 2]; // R7
        nxt_sv[PLSV_SV_DPX-PLSV_SV_LSB] = sgmii_src[PLSV_AB_SGMII_DPX]; // R8
        // fault bit has no meaning here, shown low to avoid stale flags
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sv_ff <= PLSV_SV_RST; // R13
      rf_ff <= PLSV_RF_RST; // R13
    end else begin
      sv_ff <= nxt_sv; // R12
      rf_ff <= nxt_rf;
    end
  end

  assign status_vector_o = sv_ff;
  assign remote_fault_o  = rf_ff;

endmodule

// file: verification/plsv_mgmt.sv
// Purpose: management reader model; Assumes: go_i from bench; Notes: read pulse lags go_i
`timescale 1ns/1ps
module plsv_mgmt (input wire logic sys_clk_i, input wire logic go_i, output logic rd_o);
  always_ff @(posedge sys_clk_i) rd_o <= go_i;
endmodule

// file: verification/plsv_status_assertions.sv
// Purpose: port checks; Assumes: 1 cycle latency; Notes: arm_ff skips first edge
`timescale 1ns/1ps
module plsv_status_chk (
  input wire logic        sys_clk_i, reset_i, sgmii_mode_i, phy_side_i, rf_detect_i,
  input wire logic        status_reg1_read_i, remote_fault_o,
  input wire logic [15:0] adv_ability_i, lp_ability_i,
  input wire logic [8:0]  status_vector_o
);
  logic        arm_ff, s, p;
  logic [15:0] a, l;
  always_ff @(posedge sys_clk_i or posedge reset_i)
    if (reset_i) arm_ff <= 1'b0; else arm_ff <= 1'b1;
  always_ff @(posedge sys_clk_i) {s, p, a, l} <= {sgmii_mode_i, phy_side_i, adv_ability_i,
                                                  lp_ability_i};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i || !arm_ff);
  a_basex_link: assert property (!s |-> !status_vector_o[0]) else $error("link");
  a_sgmii_link: assert property (s |-> status_vector_o[0] == (p ? a[15] : l[15]))
    else $error("link");
  a_fault_type: assert property (status_vector_o[2:1] == (!s ? l[13:12] :
    (p || l[15]) ? 2'h0 : 2'h2)) else $error("type");
  a_speed_code: assert property (status_vector_o[4:3] == (!s ? 2'h2 :
    p ? a[11:10] : l[11:10])) else $error("speed");
  a_duplex_bit: assert property (status_vector_o[5] == (!s ? l[5] : p ? a[12] : l[12]))
    else $error("duplex");
  a_pause_bits: assert property (status_vector_o[8:7] == (s ? 2'h0 : l[8:7]))
    else $error("pause");
  a_fault_set: assert property (rf_detect_i |=> remote_fault_o) else $error("set");
  a_fault_hold: assert property (remote_fault_o && !status_reg1_read_i |=> remote_fault_o)
    else $error("hold");
  a_fault_clear: assert property (status_reg1_read_i && !rf_detect_i |=> !remote_fault_o)
    else $error("clear");
  a_fault_mirror: assert property (status_vector_o[6] == (remote_fault_o && !(s && p)))
    else $error("mirror");
endmodule
bind plsv_status plsv_status_chk plsv_status_chk_i (.sys_clk_i, .reset_i, .sgmii_mode_i,
  .phy_side_i, .rf_detect_i, .status_reg1_read_i, .remote_fault_o, .adv_ability_i,
  .lp_ability_i, .status_vector_o);

// file: verification/plsv_status_tb.sv
// Purpose: random mode/word sweep; Assumes: 25 ns clock; Notes: ends with async reset
`timescale 1ns/1ps
module plsv_status_tb;
  logic        sys_clk_i = 0, reset_i = 1, sg = 0, ph = 0, rf = 0, go = 0, f = 0, rd, flt;
  logic [15:0] adv = 0, lp = 0;
  logic [8:0]  sv, e;
  int          err_total = 0, checks = 0;
  plsv_mgmt plsv_mgmt_i (.sys_clk_i, .go_i(go), .rd_o(rd));
  plsv_status plsv_status_i (.sys_clk_i, .reset_i, .sgmii_mode_i(sg), .phy_side_i(ph),
    .adv_ability_i(adv), .lp_ability_i(lp), .rf_detect_i(rf), .status_reg1_read_i(rd),
    .status_vector_o(sv), .remote_fault_o(flt));
  initial forever #12.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [8:0] xp(logic s, p, logic [15:0] a, l, logic f);
    if (!s) return {l[8:7], f, l[5], 2'h2, l[13:12], 1'b0};
    if (p) return {3'h0, a[12], a[11:10], 2'h0, a[15]};
    return {2'h0, f, l[12], l[11:10], l[15] ? 2'h0 : 2'h2, l[15]};
  endfunction
  task chk(input logic [9:0] x, y);
    checks++;
    if (y !== x) begin
      err_total++;
      $display("Error status exp %h got %h", x, y);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h62C2B1EE));
    repeat (12) @(posedge sys_clk_i);
    #1 reset_i = 0;
    for (int i = 0; i < 400; i++) begin
      @(posedge sys_clk_i);
      #1;
      if (i > 0) chk({f, e}, {flt, sv});
      {sg, ph} = 2'($urandom);
      adv = 16'($urandom);
      lp = 16'($urandom);
      rf = ($urandom % 5 == 0);
      go = ($urandom % 3 == 0);
      // hand-written corners; go leads the read strobe by one cycle
      case (i)
        101: go = 1'b1;
        102: {sg, ph, rf, go} = 4'b1110;
        103: {rf, go} = 2'b01;
        104: {sg, ph, lp[15], rf} = 4'b1000;
        105: {sg, ph, lp[15], lp[11:10]} = 5'b10111;
        default: ;
      endcase
      f = rf | (f & ~rd);
      e = xp(sg, ph, adv, lp, f);
    end
    @(posedge sys_clk_i);
    #1 reset_i = 1;
    #1 chk(10'h000, {flt, sv});
    end_sim;
  end
endmodule
